// ### rtl/occ_chan_div.sv
// module: one channel divider with sync-loaded initial phase
`timescale 1ns/1ns
`default_nettype none
module occ_chan_div
   import occ_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_reset,
   input  wire logic               i_clock_en,
   input  wire logic               i_tick,
   input  wire logic               i_sync,
   input  wire logic [DIV_W-1:0]   i_div,
   input  wire logic [PHASE_W-1:0] i_phase,
   output logic                    o_level
);
   logic [DIV_W-1:0]   cnt_q;
   logic [PHASE_W-1:0] dly_q;
   logic               wrap_w;

   // each tick is half an input period; half output = div+1 ticks
   assign wrap_w = cnt_q >= i_div;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         cnt_q   <= '0;
         dly_q   <= '0;
         o_level <= 1'b0;
      end else if (i_clock_en) begin
         if (i_sync) begin
            cnt_q   <= '0;
            dly_q   <= i_phase;
            o_level <= 1'b0;
         end else if (i_tick && dly_q != '0) begin
            dly_q <= dly_q - 6'h01;
         end else if (i_tick) begin
            cnt_q <= wrap_w ? '0 : cnt_q + 10'h001;
            if (wrap_w) begin
               o_level <= ~o_level;
            end
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_div_wrap;
      (i_clock_en && i_tick && !i_sync && dly_q == '0 && cnt_q >= i_div)
         |=> o_level != $past(o_level) && cnt_q == '0;
   endproperty
   a_div_wrap: assert property (p_div_wrap) else $error("divider missed toggle");

   property p_sync_load;
      (i_clock_en && i_sync) |=> dly_q == $past(i_phase) && !o_level;
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("phase not loaded");

   property p_phase_hold;
      (i_clock_en && !i_sync && dly_q != '0) |=> $stable(o_level) && $stable(cnt_q);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("divider ran in delay");

endmodule : occ_chan_div
`default_nettype wire

// ### rtl/occ_pkg.sv
// package: constants and carrier types of the output channel divider block
package occ_pkg;

   // ***********************************
   // widths and counts
   // ***********************************
   localparam int ADDR_W    = 10;
   localparam int DATA_W    = 8;
   localparam int NUM_CH    = 6;
   localparam int DIV_W     = 10;
   localparam int PHASE_W   = 6;
   localparam int PLL_CNT_W = 4;
   localparam int ROUTE_W   = 2;

   // ***********************************
   // register offsets
   // ***********************************
   // per-channel triples; the last channel sits at the printed offsets
   localparam logic [ADDR_W-1:0] CH_CTRL_LAST   = 10'h196;
   localparam logic [ADDR_W-1:0] CH_DIV_LO_LAST = 10'h197;
   localparam logic [ADDR_W-1:0] CH_PH_DIV_LAST = 10'h198;
   localparam int                CH_STRIDE      = 3;
   localparam logic [ADDR_W-1:0] PLL_DIV_STR    = 10'h1ba;
   localparam logic [ADDR_W-1:0] PLL_ROUTE      = 10'h1bb;
   localparam logic [ADDR_W-1:0] OUT_STATUS     = 10'h1bc;

   // ***********************************
   // field positions
   // ***********************************
   localparam int CTRL_INV_BIT  = 7;
   localparam int CTRL_IGN_BIT  = 6;
   localparam int CTRL_PD_BIT   = 5;
   localparam int MODE_MSB      = 3;
   localparam int PHASE_LSB     = 2;
   localparam int DIV_HI_MSB    = 1;
   localparam int PLL_WEAK_BIT  = 4;
   localparam int PLL_DIV_MSB   = 3;
   localparam int PLL_PD_BIT    = 7;

   // ***********************************
   // reset values and write masks
   // ***********************************
   localparam logic [DATA_W-1:0] CTRL_RST       = 8'h00;
   localparam logic [DATA_W-1:0] DIV_LO_RST     = 8'h00;
   localparam logic [DATA_W-1:0] PH_DIV_RST     = 8'h00;
   localparam logic [DATA_W-1:0] PLL_DIV_STR_RST = 8'h01;
   localparam logic [DATA_W-1:0] PLL_ROUTE_RST  = 8'h00;
   localparam logic [DATA_W-1:0] PLL_DIV_STR_MSK = 8'h1f;
   localparam logic [DATA_W-1:0] PLL_ROUTE_MSK  = 8'h83;

   // ***********************************
   // driver mode codes
   // ***********************************
   localparam logic [3:0] MODE_TRI   = 4'h0;
   localparam logic [3:0] MODE_DIF1  = 4'h1;
   localparam logic [3:0] MODE_DIF2  = 4'h2;
   localparam logic [3:0] MODE_DIF3  = 4'h3;
   localparam logic [3:0] MODE_DIF4  = 4'h4;
   localparam logic [3:0] MODE_DIF5  = 4'h5;
   localparam logic [3:0] MODE_TT    = 4'h6;
   localparam logic [3:0] MODE_TC    = 4'h7;
   localparam logic [3:0] MODE_T_Z   = 4'h8;
   localparam logic [3:0] MODE_Z_T   = 4'h9;
   localparam logic [3:0] MODE_Z_Z   = 4'ha;
   localparam logic [3:0] MODE_CC    = 4'hb;
   localparam logic [3:0] MODE_CT    = 4'hc;
   localparam logic [3:0] MODE_C_Z   = 4'hd;
   localparam logic [3:0] MODE_Z_C   = 4'he;
   localparam logic [3:0] MODE_TRI2  = 4'hf;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } occ_bus_s;

   typedef struct packed {
      logic p;
      logic p_oe;
      logic n;
      logic n_oe;
   } occ_pins_s;

endpackage : occ_pkg

// ### rtl/occ_pll_div.sv
// module: power-of-two divider for the input pll clock output
`timescale 1ns/1ns
`default_nettype none
module occ_pll_div
   import occ_pkg::*;
(
   input  wire logic                 i_clock,
   input  wire logic                 i_reset,
   input  wire logic                 i_clock_en,
   input  wire logic                 i_tick,
   input  wire logic [PLL_DIV_MSB:0] i_code,
   output logic                      o_level
);
   logic [PLL_CNT_W-1:0] cnt_q;
   logic [PLL_CNT_W-1:0] last_w;
   logic                 wrap_w;

   // other patterns still give a mask, no lock-up
   assign last_w = {i_code[3], |i_code[3:2], |i_code[3:1], |i_code};
   assign wrap_w = cnt_q >= last_w;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         cnt_q   <= '0;
         o_level <= 1'b0;
      end else if (i_clock_en && i_tick) begin
         cnt_q <= wrap_w ? '0 : cnt_q + 4'h1;
         if (wrap_w) begin
            o_level <= ~o_level;
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_pll_wrap;
      (i_clock_en && i_tick && cnt_q >= last_w) |=> (o_level != $past(o_level)) && cnt_q == '0;
   endproperty
   a_pll_wrap: assert property (p_pll_wrap) else $error("pll divider missed toggle");

endmodule : occ_pll_div
`default_nettype wire

// ### rtl/occ_top.sv
// module: output channel dividers, driver modes and input pll clock output
`timescale 1ns/1ns
`default_nettype none
module occ_top
   import occ_pkg::*;
#(
   parameter int NCH = NUM_CH
)
(
   input  wire logic                i_clock,
   input  wire logic                i_reset,
   input  wire logic                i_clock_en,
   input  wire occ_bus_s            i_bus,
   input  wire logic                i_sync,
   input  wire logic                i_vco_tick,
   input  wire logic                i_osc_tick,
   output logic [DATA_W-1:0]        o_rdata,
   output occ_pins_s [NCH-1:0]      o_ch_pins,
   output logic                     o_pll_out,
   output logic                     o_pll_out_oe,
   output logic                     o_pll_weak
);

   // ***********************************
   // driver mode decoding
   // ***********************************
   function automatic occ_pins_s drv_map(input logic [3:0] m, input logic t);
      occ_pins_s r;
      r = '0;
      unique case (m)
         MODE_TRI, MODE_TRI2: begin
            r = '0;
         end
         MODE_Z_Z: begin
            r = '0;
         end
         MODE_TC, MODE_DIF1, MODE_DIF2, MODE_DIF3, MODE_DIF4, MODE_DIF5: begin
            r = {t, 1'b1, ~t, 1'b1};
         end
         MODE_TT: begin
            r = {t, 1'b1, t, 1'b1};
         end
         MODE_T_Z: begin
            r = {t, 1'b1, 1'b0, 1'b0};
         end
         MODE_Z_T: begin
            r = {1'b0, 1'b0, t, 1'b1};
         end
         MODE_CC: begin
            r = {~t, 1'b1, ~t, 1'b1};
         end
         MODE_CT: begin
            r = {~t, 1'b1, t, 1'b1};
         end
         MODE_C_Z: begin
            r = {~t, 1'b1, 1'b0, 1'b0};
         end
         MODE_Z_C: begin
            r = {1'b0, 1'b0, ~t, 1'b1};
         end
      endcase
      return r;
   endfunction : drv_map

   // ***********************************
   // declarations
   // ***********************************
   logic [DATA_W-1:0] ctrl_q  [NCH];
   logic [DATA_W-1:0] divlo_q [NCH];
   logic [DATA_W-1:0] phdiv_q [NCH];
   logic [DATA_W-1:0] ch_rd_w [NCH];
   logic [DATA_W-1:0] pll_ds_q;
   logic [DATA_W-1:0] route_q;
   logic [NCH-1:0]    lvl_w;
   logic [NCH-1:0]    true_w;
   occ_pins_s [NCH-1:0] pins_d;
   logic              sync_m_q;
   logic              sync_s_q;
   logic              sync_d_q;
   logic              sync_pulse_w;
   logic              pll_lvl_w;
   logic              pll_pd_w;
   logic [DATA_W-1:0] status_w;
   logic [DATA_W-1:0] rd_ch_w;
   logic [DATA_W-1:0] rd_mux_w;
   logic              wr_pll_w;
   logic              wr_route_w;

   // ***********************************
   // chip-level sync
   // ***********************************
   // pin is asynchronous: two flops, then edge detect on the second
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         sync_m_q <= 1'b0;
         sync_s_q <= 1'b0;
         sync_d_q <= 1'b0;
      end else if (i_clock_en) begin
         sync_m_q <= i_sync;
         sync_s_q <= sync_m_q;
         sync_d_q <= sync_s_q;
      end
   end
   assign sync_pulse_w = sync_s_q & ~sync_d_q;

   // ***********************************
   // channels
   // ***********************************
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      localparam int DL = CH_STRIDE * (NCH - 1 - i);
      localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(int'(CH_CTRL_LAST) - DL);
      localparam logic [ADDR_W-1:0] A_DLO  = ADDR_W'(int'(CH_DIV_LO_LAST) - DL);
      localparam logic [ADDR_W-1:0] A_PH   = ADDR_W'(int'(CH_PH_DIV_LAST) - DL);
      wire logic wr_ctrl_w = i_bus.wr && i_bus.addr == A_CTRL;
      wire logic wr_dlo_w  = i_bus.wr && i_bus.addr == A_DLO;
      wire logic wr_ph_w   = i_bus.wr && i_bus.addr == A_PH;
      wire logic tick_w;
      wire logic sync_w;
      wire logic [DIV_W-1:0] div_w;

      always_ff @(posedge i_clock or posedge i_reset) begin
         if (i_reset) begin
            ctrl_q[i]  <= CTRL_RST;
            divlo_q[i] <= DIV_LO_RST;
            phdiv_q[i] <= PH_DIV_RST;
         end else if (i_clock_en) begin
            if (wr_ctrl_w) begin
               ctrl_q[i] <= i_bus.wdata;
            end
            if (wr_dlo_w) begin
               divlo_q[i] <= i_bus.wdata;
            end
            if (wr_ph_w) begin
               phdiv_q[i] <= i_bus.wdata;
            end
         end
      end

      assign ch_rd_w[i] = (i_bus.addr == A_CTRL) ? ctrl_q[i]  :
                          (i_bus.addr == A_DLO)  ? divlo_q[i] :
                          (i_bus.addr == A_PH)   ? phdiv_q[i] : '0;

      if (i < ROUTE_W) begin : g_route
         assign tick_w = route_q[i] ? i_osc_tick : i_vco_tick;
      end else begin : g_vco
         assign tick_w = i_vco_tick;
      end

      assign sync_w = sync_pulse_w & ~ctrl_q[i][CTRL_IGN_BIT];
      assign div_w  = {phdiv_q[i][DIV_HI_MSB:0], divlo_q[i]};

      occ_chan_div u_div (
         .i_clock    (i_clock),
         .i_reset    (i_reset),
         .i_clock_en (i_clock_en),
         .i_tick     (tick_w),
         .i_sync     (sync_w),
         .i_div      (div_w),
         .i_phase    (phdiv_q[i][DATA_W-1:PHASE_LSB]),
         .o_level    (lvl_w[i])
      );

      assign true_w[i] = lvl_w[i] ^ ctrl_q[i][CTRL_INV_BIT];
      // powered-down channel lets go of both pins
      assign pins_d[i] = ctrl_q[i][CTRL_PD_BIT] ? '0 :
                         drv_map(ctrl_q[i][MODE_MSB:0], true_w[i]);
   end

   // ***********************************
   // input pll clock output
   // ***********************************
   assign wr_pll_w   = i_bus.wr && i_bus.addr == PLL_DIV_STR;
   assign wr_route_w = i_bus.wr && i_bus.addr == PLL_ROUTE;

   // reserved bits are masked so they always read zero
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         pll_ds_q <= PLL_DIV_STR_RST;
         route_q  <= PLL_ROUTE_RST;
      end else if (i_clock_en) begin
         if (wr_pll_w) begin
            pll_ds_q <= i_bus.wdata & PLL_DIV_STR_MSK;
         end
         if (wr_route_w) begin
            route_q <= i_bus.wdata & PLL_ROUTE_MSK;
         end
      end
   end

   occ_pll_div u_pll_div (
      .i_clock    (i_clock),
      .i_reset    (i_reset),
      .i_clock_en (i_clock_en),
      .i_tick     (i_osc_tick),
      .i_code     (pll_ds_q[PLL_DIV_MSB:0]),
      .o_level    (pll_lvl_w)
   );

   assign pll_pd_w = route_q[PLL_PD_BIT];

   // ***********************************
   // read path
   // ***********************************
   always_comb begin
      rd_ch_w = '0;
      for (int k = 0; k < NCH; k++) begin
         rd_ch_w = rd_ch_w | ch_rd_w[k];
      end
   end

   assign status_w = DATA_W'({pll_lvl_w, lvl_w});
   assign rd_mux_w = (i_bus.addr == PLL_DIV_STR) ? pll_ds_q :
                     (i_bus.addr == PLL_ROUTE)   ? route_q  :
                     (i_bus.addr == OUT_STATUS)  ? status_w : rd_ch_w;

   // ***********************************
   // output registers
   // ***********************************
   // pins are retimed: one cycle of latency traded for glitch-free pads
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_rdata      <= '0;
         o_ch_pins    <= '0;
         o_pll_out    <= 1'b0;
         o_pll_out_oe <= 1'b0;
         o_pll_weak   <= 1'b0;
      end else if (i_clock_en) begin
         o_rdata      <= i_bus.rd ? rd_mux_w : '0;
         o_ch_pins    <= pins_d;
         o_pll_out    <= pll_pd_w ? 1'b0 : pll_lvl_w;
         o_pll_out_oe <= ~pll_pd_w;
         o_pll_weak   <= pll_ds_q[PLL_WEAK_BIT];
      end
   end

   // ***********************************
   // assertions on channel 0 and the pll output
   // ***********************************
   logic [3:0] mode0_w;
   logic       go0_w;
   assign mode0_w = ctrl_q[0][MODE_MSB:0];
   assign go0_w   = i_clock_en && !ctrl_q[0][CTRL_PD_BIT];

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_mode_tc;
      (go0_w && mode0_w == MODE_TC) |=> o_ch_pins[0] == {$past(true_w[0]), 1'b1,
                                                        ~$past(true_w[0]), 1'b1};
   endproperty
   a_mode_tc: assert property (p_mode_tc) else $error("mode 0111 pins wrong");

   property p_mode_one_z;
      (go0_w && mode0_w == MODE_T_Z) |=> o_ch_pins[0].p_oe && !o_ch_pins[0].n_oe
                                          && o_ch_pins[0].p == $past(true_w[0]);
   endproperty
   a_mode_one_z: assert property (p_mode_one_z) else $error("mode 1000 pins wrong");

   property p_mode_zz;
      (go0_w && mode0_w == MODE_Z_Z) ##1 (go0_w && mode0_w == MODE_Z_Z)
         |=> !o_ch_pins[0].p_oe && !o_ch_pins[0].n_oe;
   endproperty
   a_mode_zz: assert property (p_mode_zz) else $error("mode 1010 not high-Z");

   property p_mode_cc;
      (go0_w && mode0_w == MODE_CC) |=> o_ch_pins[0].p == ~$past(true_w[0])
                                         && o_ch_pins[0].n == o_ch_pins[0].p;
   endproperty
   a_mode_cc: assert property (p_mode_cc) else $error("mode 1011 pins wrong");

   property p_mode_ct;
      (go0_w && mode0_w == MODE_CT) |=> o_ch_pins[0].n == $past(true_w[0])
                                         && o_ch_pins[0].p != o_ch_pins[0].n;
   endproperty
   a_mode_ct: assert property (p_mode_ct) else $error("mode 1100 pins wrong");

   property p_mode_zc;
      (go0_w && mode0_w == MODE_Z_C) |=> !o_ch_pins[0].p_oe && o_ch_pins[0].n_oe
                                          && o_ch_pins[0].n == ~$past(true_w[0]);
   endproperty
   a_mode_zc: assert property (p_mode_zc) else $error("mode 1110 pins wrong");

   property p_mode_tri;
      (i_clock_en && mode0_w == MODE_TRI2) |=> o_ch_pins[0] == '0;
   endproperty
   a_mode_tri: assert property (p_mode_tri) else $error("mode 1111 not tristate");

   property p_div_low;
      (i_clock_en && i_bus.wr && i_bus.addr == ADDR_W'(int'(CH_DIV_LO_LAST)
         - CH_STRIDE * (NCH - 1))) |=> divlo_q[0] == $past(i_bus.wdata);
   endproperty
   a_div_low: assert property (p_div_low) else $error("divider low byte lost");

   property p_weak;
      (i_clock_en && wr_pll_w) ##1 i_clock_en |=> o_pll_weak == $past(i_bus.wdata[PLL_WEAK_BIT], 2);
   endproperty
   a_weak: assert property (p_weak) else $error("drive strength not applied");

   property p_pll_pd;
      (i_clock_en && pll_pd_w) |=> !o_pll_out_oe && !o_pll_out;
   endproperty
   a_pll_pd: assert property (p_pll_pd) else $error("pll output not powered down");

   property c_sync_phase;
      (sync_pulse_w && phdiv_q[0][DATA_W-1:PHASE_LSB] != '0 && i_clock_en);
   endproperty
   cv_sync_phase: cover property (c_sync_phase);

   property c_route_osc;
      (i_clock_en && wr_route_w && i_bus.wdata[0]);
   endproperty
   cv_route_osc: cover property (c_route_osc);

   property c_status_rd;
      (i_clock_en && i_bus.rd && i_bus.addr == OUT_STATUS);
   endproperty
   cv_status_rd: cover property (c_status_rd);

endmodule : occ_top
`default_nettype wire

// ### verification/occ_tick_src.sv
// partner model: vco divider and oscillator half-period tick sources
`timescale 1ns/1ns
`default_nettype none
module occ_tick_src (
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_vco_run,
   input  wire logic i_osc_run,
   input  wire logic i_slow,
   output logic      o_vco_tick,
   output logic      o_osc_tick
);
   // ***********************************
   // tick generation
   // ***********************************
   logic phase_q;
   // slow mode: one tick every other cycle, a half-rate source
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         phase_q    <= 1'b0;
         o_vco_tick <= 1'b0;
         o_osc_tick <= 1'b0;
      end else begin
         phase_q    <= ~phase_q;
         o_vco_tick <= i_vco_run & (~i_slow | phase_q);
         o_osc_tick <= i_osc_run & (~i_slow | phase_q);
      end
   end
endmodule : occ_tick_src
`default_nettype wire

// ### verification/tb.sv
// testbench: registers, driver modes, dividers, sync and pll output
`timescale 1ns/1ns
`default_nettype none
module tb
   import occ_pkg::*;
();
   // ***********************************
   // signals and instances
   // ***********************************
   logic                   i_clock;
   logic                   i_reset;
   logic                   i_sync;
   logic                   vco_run;
   logic                   osc_run;
   logic                   slow;
   logic                   clk_en;
   logic                   vco_tick;
   logic                   osc_tick;
   occ_bus_s               bus;
   logic [DATA_W-1:0]      rdata;
   occ_pins_s [NUM_CH-1:0] pins;
   logic                   pll_out;
   logic                   pll_oe;
   logic                   pll_weak;
   int                     num_errors;
   int                     checks_done;
   int                     wsel;
   int                     n;
   int                     t4;
   int                     t5;
   int                     dv[3] = '{0, 258, 1023};
   int                     ph[2] = '{1, 63};
   logic [3:0]             pc[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
   wire                    watched = (wsel == NUM_CH) ? pll_out : pins[wsel].p;

   occ_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_en(clk_en), .i_bus(bus),
      .i_sync(i_sync), .i_vco_tick(vco_tick), .i_osc_tick(osc_tick), .o_rdata(rdata),
      .o_ch_pins(pins), .o_pll_out(pll_out), .o_pll_out_oe(pll_oe), .o_pll_weak(pll_weak));
   occ_tick_src src (.i_clock(i_clock), .i_reset(i_reset), .i_vco_run(vco_run),
      .i_osc_run(osc_run), .i_slow(slow), .o_vco_tick(vco_tick), .o_osc_tick(osc_tick));

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   // ***********************************
   // checks and bus tasks
   // ***********************************
   task automatic fail(input string msg);
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask : fail
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
   endtask : chk8
   task automatic chk_pins(input occ_pins_s got, input occ_pins_s exp);
      checks_done++;
      if (got !== exp) fail($sformatf("pins %b expected %b", got, exp));
   endtask : chk_pins
   task automatic chk_n(input int got, input int exp);
      checks_done++;
      if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
   endtask : chk_n
   task automatic wr(input int a, input logic [7:0] d);
      @(posedge i_clock);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a[ADDR_W-1:0], wdata: d};
      @(posedge i_clock);
      bus <= '0;
   endtask : wr
   task automatic rd_chk(input int a, input logic [7:0] exp);
      @(posedge i_clock);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a[ADDR_W-1:0], wdata: 8'h00};
      @(posedge i_clock);
      bus <= '0;
      #1 chk8(rdata, exp);
   endtask : rd_chk
   function automatic int ctl(input int ch);
      return CH_CTRL_LAST - CH_STRIDE * (NUM_CH - 1 - ch);
   endfunction : ctl
   task automatic cfg(input int ch, input logic [7:0] c, input logic [9:0] d,
                      input logic [5:0] p);
      wr(ctl(ch), c);
      wr(ctl(ch) + 1, d[7:0]);
      wr(ctl(ch) + 2, {p, d[9:8]});
   endtask : cfg
   task automatic sync_pulse();
      @(posedge i_clock);
      i_sync <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_sync <= 1'b0;
      repeat (5) @(negedge i_clock);
   endtask : sync_pulse
   task automatic tick(input logic v, input logic o);
      @(posedge i_clock);
      vco_run <= v;
      osc_run <= o;
      @(posedge i_clock);
      vco_run <= 1'b0;
      osc_run <= 1'b0;
      repeat (3) @(negedge i_clock);
   endtask : tick
   // skips the first change, then counts cycles to the next one
   task automatic measure(output int cnt);
      logic last;
      cnt = 0;
      last = watched;
      for (int i = 0; i < 3000 && watched === last; i++) @(negedge i_clock);
      last = watched;
      for (int i = 0; i < 3000 && watched === last; i++) begin
         @(negedge i_clock);
         cnt++;
      end
   endtask : measure
   function automatic occ_pins_s exp_pins(input logic [3:0] m, input logic t);
      case (m)
         4'h6: return '{t, 1'b1, t, 1'b1};
         4'h8: return '{t, 1'b1, 1'b0, 1'b0};
         4'h9: return '{1'b0, 1'b0, t, 1'b1};
         4'hb: return '{~t, 1'b1, ~t, 1'b1};
         4'hc: return '{~t, 1'b1, t, 1'b1};
         4'hd: return '{~t, 1'b1, 1'b0, 1'b0};
         4'he: return '{1'b0, 1'b0, ~t, 1'b1};
         4'h0, 4'ha, 4'hf: return '0;
         default: return '{t, 1'b1, ~t, 1'b1};
      endcase
   endfunction : exp_pins
   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   initial begin
      #(40 * 20000);
      fail("watchdog expired");
      print_verdict();
   end

   // ***********************************
   // test sequence
   // ***********************************
   initial begin
      i_reset = 1'b1;
      i_sync = 1'b0;
      bus = '0;
      vco_run = 1'b0;
      osc_run = 1'b0;
      slow = 1'b0;
      clk_en = 1'b1;
      wsel = 0;
      num_errors = 0;
      checks_done = 0;
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      rd_chk(PLL_DIV_STR, 8'h01);
      rd_chk(PLL_ROUTE, 8'h00);
      rd_chk(ctl(0), 8'h00);
      rd_chk(10'h3ff, 8'h00);
      chk8({7'h0, pll_oe}, 8'h01);
      // reserved bits dropped, code 0000 stays legal
      wr(PLL_DIV_STR, 8'hf0);
      rd_chk(PLL_DIV_STR, 8'h10);
      chk8({7'h0, pll_weak}, 8'h01);
      // divider level is 0 after reset and ticks are off
      for (int inv = 0; inv < 2; inv++) begin
         for (int m = 0; m < 16; m++) begin
            wr(ctl(5), {inv[0], 3'b000, m[3:0]});
            wr(ctl(0), {inv[0], 3'b000, m[3:0]});
            repeat (2) @(negedge i_clock);
            chk_pins(pins[5], exp_pins(m[3:0], inv[0]));
            chk_pins(pins[0], exp_pins(m[3:0], inv[0]));
         end
      end
      wsel = 5;
      foreach (dv[i]) begin
         cfg(5, 8'h07, dv[i][9:0], 6'h00);
         sync_pulse();
         @(posedge i_clock);
         vco_run <= 1'b1;
         measure(n);
         chk_n(n, dv[i] + 1);
         @(posedge i_clock);
         vco_run <= 1'b0;
      end
      foreach (ph[i]) begin
         cfg(4, 8'h07, 10'h001, 6'h00);
         cfg(5, 8'h07, 10'h001, ph[i][5:0]);
         sync_pulse();
         @(posedge i_clock);
         vco_run <= 1'b1;
         t4 = 0;
         t5 = 0;
         for (int c = 1; c < 200 && t5 == 0; c++) begin
            @(negedge i_clock);
            if (t4 == 0 && pins[4].p === 1'b1) t4 = c;
            if (t5 == 0 && pins[5].p === 1'b1) t5 = c;
         end
         chk_n(t5 - t4, ph[i]);
         @(posedge i_clock);
         vco_run <= 1'b0;
      end
      cfg(4, 8'h07, 10'h000, 6'h00);
      cfg(5, 8'h07, 10'h000, 6'h00);
      sync_pulse();
      tick(1'b1, 1'b0);
      wr(ctl(5), 8'h47);
      sync_pulse();
      chk_pins(pins[4], exp_pins(4'h7, 1'b0));
      chk_pins(pins[5], exp_pins(4'h7, 1'b1));
      cfg(0, 8'h07, 10'h000, 6'h00);
      cfg(1, 8'h07, 10'h000, 6'h00);
      sync_pulse();
      wr(PLL_ROUTE, 8'h01);
      tick(1'b0, 1'b1);
      chk_pins(pins[0], exp_pins(4'h7, 1'b1));
      chk_pins(pins[1], exp_pins(4'h7, 1'b0));
      wr(PLL_ROUTE, 8'h02);
      tick(1'b0, 1'b1);
      chk_pins(pins[0], exp_pins(4'h7, 1'b1));
      chk_pins(pins[1], exp_pins(4'h7, 1'b1));
      // levels: ch0, ch1 and ch5 high, pll divider back low
      rd_chk(OUT_STATUS, 8'h23);
      wsel = NUM_CH;
      foreach (pc[k]) begin
         wr(PLL_DIV_STR, {3'b000, k[0], pc[k]});
         @(posedge i_clock);
         slow <= k[0];
         osc_run <= 1'b1;
         measure(n);
         chk_n(n, (1 << k) * (k[0] + 1));
         chk8({7'h0, pll_weak}, {7'h0, k[0]});
         // stop ticks so the next rate starts on a clean tick pattern
         @(posedge i_clock);
         osc_run <= 1'b0;
      end
      wr(PLL_ROUTE, 8'hff);
      rd_chk(PLL_ROUTE, 8'h83);
      chk8({6'h0, pll_oe, pll_out}, 8'h00);
      // frozen block must ignore a write
      @(posedge i_clock);
      clk_en <= 1'b0;
      wr(PLL_ROUTE, 8'h00);
      @(posedge i_clock);
      clk_en <= 1'b1;
      rd_chk(PLL_ROUTE, 8'h83);
      chk8({6'h0, pll_oe, pll_out}, 8'h00);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
